// [verilog/scd_decoder.sv]
// scd_decoder: serial command byte decoder with register steering
//
// Overview of operation
// - No register transfer happens unless a command byte opened it.
// - The last command picks the target register and transfer direction.
// - Bit 6 low makes the next transfer a write, high makes it a read.
// - Bits 5:0 pick status, mode, checksum, data, pin, id, channels, offset or gain.
// - Codes 100000 to 100011 pick setup registers zero to three.
// - Codes 101000 to 101011 pick filter registers zero to three.
// - The write-only command register sits at zero and resets to zero.
module scd_decoder
  import scd_pkg::*;
(
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  input  wire logic                              spi_sclk,
  input  wire logic                              spi_cs_n,
  input  wire logic                              spi_din,
  output logic                                   spi_dout,
  output logic                                   spi_dout_oe,
  output logic [scd_pkg::SCD_CMD_W-1:0]          command_reg,
  output logic [scd_pkg::SCD_ADDR_W-1:0]         target_reg_sel,
  output logic                                   target_valid,
  output logic                                   target_read,
  output logic                                   cmd_strobe,
  output logic                                   rd_strobe,
  input  wire logic [scd_pkg::SCD_DATA_W-1:0]    rd_data,
  output logic                                   wr_strobe,
  output logic [scd_pkg::SCD_DATA_W-1:0]         wr_data
);

  // reset release and crossings
  logic                  rst_q;
  logic                  link_arst_n;
  logic                  cmd_sync_q;
  logic                  wr_sync_q;

  // link domain
  scd_link_t             state_ff;
  scd_link_t             nxt_state;
  logic [SCD_CNT_W-1:0]  bit_cnt_ff;
  logic [SCD_CNT_W-1:0]  nxt_bit_cnt;
  logic [SCD_DATA_W-1:0] shift_ff;
  logic [SCD_DATA_W-1:0] nxt_shift;
  logic [SCD_CMD_W-1:0]  cmd_reg_ff;
  logic [SCD_CNT_W-1:0]  len_ff;
  logic                  cmd_tgl_ff;
  logic                  wr_tgl_ff;
  logic [SCD_DATA_W-1:0] wr_word_ff;
  logic                  dout_ff;
  logic                  dout_oe_ff;

  // system domain
  logic                  cmd_seen_ff;
  logic                  wr_seen_ff;
  logic                  ack_pend_ff;
  logic [SCD_DATA_W-1:0] rd_hold_ff;
  logic [SCD_CMD_W-1:0]  command_reg_ff;
  logic [SCD_ADDR_W-1:0] target_sel_ff;
  logic                  target_valid_ff;
  logic                  target_read_ff;
  logic                  cmd_strobe_ff;
  logic                  rd_strobe_ff;
  logic                  wr_strobe_ff;
  logic [SCD_DATA_W-1:0] wr_data_ff;

  scd_sync u_rst_sync (
    .clk    (sys_clk),
    .arst_n (rst_n),
    .d      (1'b1),
    .q      (rst_q)
  );

  // a frame ends by chip select alone, since the link clock stops outside
  assign link_arst_n = rst_q & ~spi_cs_n;

  // link decode
  wire [SCD_CMD_W-1:0]  byte_in   = {shift_ff[6:0], spi_din};
  wire [SCD_DATA_W-1:0] word_in   = {shift_ff[SCD_DATA_W-2:0], spi_din};
  wire [SCD_CNT_W-1:0]  new_len   = scd_reg_len(byte_in[SCD_ADDR_MSB:0]);
  wire [SCD_CNT_W-1:0]  len_last  = len_ff - SCD_CNT_ONE;
  wire                  cmd_done  = (state_ff == SCD_CMD) &&
                                    (bit_cnt_ff == SCD_CMD_LAST);
  wire                  cmd_ok    = cmd_done && !byte_in[SCD_WEN_BIT];
  wire                  in_data   = (state_ff == SCD_WR) ||
                                    (state_ff == SCD_RD);
  wire                  data_done = in_data && (bit_cnt_ff == len_last);
  wire                  wr_done   = data_done && (state_ff == SCD_WR);
  wire [SCD_CNT_W-1:0]  rd_idx    = len_last - bit_cnt_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SCD_CMD: begin
        if (cmd_ok) begin
          if (new_len == SCD_LEN_NONE) begin
            nxt_state = SCD_SKIP;
          end else if (byte_in[SCD_DIR_BIT] == SCD_DIR_READ) begin
            nxt_state = SCD_RD;
          end else begin
            nxt_state = SCD_WR;
          end
        end
      end
      SCD_WR: begin
        if (data_done) begin
          nxt_state = SCD_CMD;
        end
      end
      SCD_RD: begin
        if (data_done) begin
          nxt_state = SCD_CMD;
        end
      end
      SCD_SKIP: nxt_state = SCD_SKIP;
    endcase
  end

  assign nxt_bit_cnt = (cmd_done || data_done) ? '0 :
                       (state_ff == SCD_SKIP)  ? bit_cnt_ff :
                       bit_cnt_ff + SCD_CNT_ONE;
  // clear after the command so a short write lands in the low bits
  assign nxt_shift   = cmd_done ? '0 : word_in;

  always_ff @(posedge spi_sclk or negedge link_arst_n) begin
    if (!link_arst_n) begin
      state_ff   <= SCD_CMD;
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
    end
  end

  // held across frames: the system side reads these after the toggle
  always_ff @(posedge spi_sclk or negedge rst_q) begin
    if (!rst_q) begin
      cmd_reg_ff <= SCD_CMD_RST;
      len_ff     <= SCD_LEN_NONE;
      cmd_tgl_ff <= 1'b0;
      wr_tgl_ff  <= 1'b0;
      wr_word_ff <= '0;
    end else begin
      if (cmd_ok) begin
        cmd_reg_ff <= byte_in;
        len_ff     <= new_len;
        cmd_tgl_ff <= ~cmd_tgl_ff;
      end
      if (wr_done) begin
        wr_word_ff <= word_in;
        wr_tgl_ff  <= ~wr_tgl_ff;
      end
    end
  end

  // read data leaves on the falling edge, msb first; the link clock stands
  // still in the host's pause, so no synchroniser could see an ack in time
  always_ff @(negedge spi_sclk or negedge link_arst_n) begin
    if (!link_arst_n) begin
      dout_ff    <= 1'b0;
      dout_oe_ff <= 1'b0;
    end else begin
      dout_oe_ff <= (state_ff == SCD_RD);
      dout_ff    <= (state_ff == SCD_RD) && rd_hold_ff[rd_idx];
    end
  end

  scd_sync u_cmd_sync (
    .clk    (sys_clk),
    .arst_n (rst_q),
    .d      (cmd_tgl_ff),
    .q      (cmd_sync_q)
  );

  scd_sync u_wr_sync (
    .clk    (sys_clk),
    .arst_n (rst_q),
    .d      (wr_tgl_ff),
    .q      (wr_sync_q)
  );

  // system side
  wire cmd_evt  = cmd_sync_q ^ cmd_seen_ff;
  wire wr_evt   = wr_sync_q ^ wr_seen_ff;
  wire evt_read = cmd_reg_ff[SCD_DIR_BIT] == SCD_DIR_READ;
  wire evt_hit  = len_ff != SCD_LEN_NONE;

  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      cmd_seen_ff     <= 1'b0;
      wr_seen_ff      <= 1'b0;
      command_reg_ff  <= SCD_CMD_RST;
      target_sel_ff   <= SCD_CMD_OFFSET;
      target_valid_ff <= 1'b0;
      target_read_ff  <= 1'b0;
      cmd_strobe_ff   <= 1'b0;
      rd_strobe_ff    <= 1'b0;
    end else begin
      cmd_seen_ff   <= cmd_sync_q;
      wr_seen_ff    <= wr_sync_q;
      cmd_strobe_ff <= cmd_evt;
      rd_strobe_ff  <= cmd_evt && evt_read && evt_hit;
      if (cmd_evt) begin
        command_reg_ff  <= cmd_reg_ff;
        target_sel_ff   <= cmd_reg_ff[SCD_ADDR_MSB:0];
        target_valid_ff <= evt_hit;
        target_read_ff  <= evt_read;
      end
    end
  end

  // read word captured a few cycles after the command and then held still;
  // limitation: a host that skips its pause before the read bits gets junk
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      ack_pend_ff  <= 1'b0;
      rd_hold_ff   <= '0;
      wr_strobe_ff <= 1'b0;
      wr_data_ff   <= '0;
    end else begin
      ack_pend_ff  <= cmd_evt;
      wr_strobe_ff <= wr_evt && target_valid_ff && !target_read_ff;
      if (ack_pend_ff) begin
        rd_hold_ff <= rd_strobe_ff ? rd_data : '0;
      end
      if (wr_evt) begin
        wr_data_ff <= wr_word_ff;
      end
    end
  end

  assign spi_dout       = dout_ff;
  assign spi_dout_oe    = dout_oe_ff;
  assign command_reg    = command_reg_ff;
  assign target_reg_sel = target_sel_ff;
  assign target_valid   = target_valid_ff;
  assign target_read    = target_read_ff;
  assign cmd_strobe     = cmd_strobe_ff;
  assign rd_strobe      = rd_strobe_ff;
  assign wr_strobe      = wr_strobe_ff;
  assign wr_data        = wr_data_ff;

  // checks
  bad_start_a: assert property (
    @(posedge spi_sclk) disable iff (!link_arst_n)
    (cmd_done && byte_in[SCD_WEN_BIT]) |=> (state_ff == SCD_CMD) &&
      $stable(cmd_tgl_ff))
    else $error("command with bit 7 high was accepted");

  dir_select_a: assert property (
    @(posedge spi_sclk) disable iff (!link_arst_n)
    (cmd_ok && new_len != SCD_LEN_NONE) |=>
      state_ff == ($past(byte_in[SCD_DIR_BIT]) ? SCD_RD : SCD_WR))
    else $error("direction bit did not steer the transfer");

  cmd_store_a: assert property (
    @(posedge spi_sclk) disable iff (!rst_q)
    cmd_ok |=> cmd_reg_ff == $past(byte_in) && cmd_tgl_ff != $past(cmd_tgl_ff))
    else $error("command byte not stored");

  setup_map_a: assert property (
    @(posedge spi_sclk) disable iff (!rst_q)
    (cmd_ok && byte_in[SCD_ADDR_MSB:2] == 4'h8) |=> len_ff == SCD_LEN_16)
    else $error("setup code did not select a setup register");

  filt_map_a: assert property (
    @(posedge spi_sclk) disable iff (!rst_q)
    (cmd_ok && byte_in[SCD_ADDR_MSB:2] == 4'hA) |=> len_ff == SCD_LEN_16)
    else $error("filter code did not select a filter register");

  cal_map_a: assert property (
    @(posedge spi_sclk) disable iff (!rst_q)
    (cmd_ok && byte_in[SCD_ADDR_MSB:4] == 2'b11 && !byte_in[2]) |=>
      len_ff == SCD_LEN_24)
    else $error("calibration code did not select a 24 bit register");

  known_map_a: assert property (
    @(posedge spi_sclk) disable iff (!rst_q)
    (cmd_ok && byte_in[SCD_ADDR_MSB:0] == SCD_A_STATUS) |=>
      len_ff == SCD_LEN_8)
    else $error("status code did not select an 8 bit register");

  wr_after_cmd_a: assert property (
    @(posedge sys_clk) disable iff (!rst_q)
    wr_strobe_ff |-> target_valid_ff && !target_read_ff)
    else $error("write strobe without an opening write command");

  sel_update_a: assert property (
    @(posedge sys_clk) disable iff (!rst_q)
    cmd_evt |=> (target_sel_ff == $past(cmd_reg_ff[SCD_ADDR_MSB:0]) &&
      cmd_strobe_ff) ##1 (!cmd_strobe_ff || $past(cmd_evt)))
    else $error("target select did not follow the command");

  rd_ack_a: assert property (
    @(posedge sys_clk) disable iff (!rst_q)
    $rose(rd_strobe_ff) |=> rd_hold_ff == $past(rd_data))
    else $error("read word not captured one cycle after the request");

  cmd_reset_a: assert property (
    @(posedge sys_clk)
    !rst_q |-> command_reg_ff == SCD_CMD_RST && !target_valid_ff)
    else $error("command register not zero in reset");

endmodule // scd_decoder

// [verilog/scd_pkg.sv]
// scd_pkg: constants and types for the serial command register decoder
package scd_pkg;

  localparam int unsigned SCD_CMD_W    = 8;
  localparam int unsigned SCD_DATA_W   = 24;
  localparam int unsigned SCD_ADDR_W   = 6;
  localparam int unsigned SCD_CNT_W    = 5;

  // command byte layout
  localparam int unsigned SCD_WEN_BIT  = 7;
  localparam int unsigned SCD_DIR_BIT  = 6;
  localparam int unsigned SCD_ADDR_MSB = 5;

  localparam logic [5:0] SCD_CMD_OFFSET = 6'h00;
  localparam logic [7:0] SCD_CMD_RST    = 8'h00;
  localparam logic       SCD_DIR_WRITE  = 1'b0;
  localparam logic       SCD_DIR_READ   = 1'b1;

  // target register address codes
  localparam logic [5:0] SCD_A_STATUS  = 6'h00;
  localparam logic [5:0] SCD_A_ADCMODE = 6'h01;
  localparam logic [5:0] SCD_A_IFMODE  = 6'h02;
  localparam logic [5:0] SCD_A_REGCHK  = 6'h03;
  localparam logic [5:0] SCD_A_DATA    = 6'h04;
  localparam logic [5:0] SCD_A_PINCFG  = 6'h06;
  localparam logic [5:0] SCD_A_IDENT   = 6'h07;
  localparam logic [3:0] SCD_G_CHAN    = 4'h4;
  localparam logic [3:0] SCD_G_SETUP   = 4'h8;
  localparam logic [3:0] SCD_G_FILT    = 4'hA;
  localparam logic [3:0] SCD_G_OFFS    = 4'hC;
  localparam logic [3:0] SCD_G_GAIN    = 4'hE;

  // transfer lengths in bits that follow the command byte, then the bit counter constants
  localparam logic [4:0] SCD_LEN_NONE = 5'h00;
  localparam logic [4:0] SCD_LEN_8    = 5'h08;
  localparam logic [4:0] SCD_LEN_16   = 5'h10;
  localparam logic [4:0] SCD_LEN_24   = 5'h18;
  localparam logic [4:0] SCD_CMD_LAST = 5'h07;
  localparam logic [4:0] SCD_CNT_ONE  = 5'h01;

  typedef enum logic [1:0] {
    SCD_CMD,
    SCD_WR,
    SCD_RD,
    SCD_SKIP
  } scd_link_t;

  // length of the addressed register, zero for an unlisted code
  function automatic logic [4:0] scd_reg_len(input logic [5:0] addr);
    logic [4:0] len;
    len = SCD_LEN_NONE;
    unique case (addr)
      SCD_A_STATUS:  len = SCD_LEN_8;
      SCD_A_ADCMODE: len = SCD_LEN_16;
      SCD_A_IFMODE:  len = SCD_LEN_16;
      SCD_A_REGCHK:  len = SCD_LEN_24;
      SCD_A_DATA:    len = SCD_LEN_24;
      SCD_A_PINCFG:  len = SCD_LEN_16;
      SCD_A_IDENT:   len = SCD_LEN_16;
      default: begin
        // grouped banks: bits 5:2 pick the bank, bits 1:0 the index
        unique case (addr[5:2])
          SCD_G_CHAN:  len = SCD_LEN_16;
          SCD_G_SETUP: len = SCD_LEN_16;
          SCD_G_FILT:  len = SCD_LEN_16;
          SCD_G_OFFS:  len = SCD_LEN_24;
          SCD_G_GAIN:  len = SCD_LEN_24;
          default:     len = SCD_LEN_NONE;
        endcase
      end
    endcase
    return len;
  endfunction

endpackage : scd_pkg

// [verilog/scd_sync.sv]
// scd_sync: two flip-flop level synchroniser
module scd_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      q       <= 1'b0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // scd_sync

// [dv/scd_host_model.sv]
// scd_host_model: host side of the serial link, mode 3 framing
module scd_host_model (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_din,
  input  wire logic spi_dout,
  input  wire logic spi_dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF_NS = 15;

  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_din  = 1'b1;
  end

  // a bit the device does not drive reads as unknown and never matches
  task automatic clk_bit(input logic b, output logic got);
    spi_sclk = 1'b0;
    spi_din  = b;
    #HALF_NS;
    spi_sclk = 1'b1;
    got      = (spi_dout_oe === 1'b1) ? spi_dout : 1'bx;
    #HALF_NS;
  endtask

  task automatic xfer(input logic [7:0] cmd, input int nbits,
                      input logic [23:0] wdata, output logic [23:0] rdata);
    logic b;
    rdata = '0;
    spi_cs_n = 1'b0;
    #HALF_NS;
    for (int i = 7; i >= 0; i--) clk_bit(cmd[i], b);
    // sclk held high so the register bank can answer before the shift out
    if (cmd[6]) #300;
    for (int i = nbits - 1; i >= 0; i--) begin
      clk_bit(wdata[i], b);
      rdata = {rdata[22:0], b};
    end
    #HALF_NS;
    spi_cs_n = 1'b1;
    // a released line shows the inverse so stale data never looks valid
    spi_din  = ~spi_din;
    #200;
  endtask
endmodule  // scd_host_model

// [dv/test_serial_command_register_decoder.sv]
// test_serial_command_register_decoder: self-checking bench for scd_decoder
module test_serial_command_register_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import scd_pkg::*;

  logic                  sys_clk = 1'b0;
  logic                  rst_n   = 1'b0;
  logic                  spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe;
  logic [SCD_CMD_W-1:0]  command_reg;
  logic [SCD_ADDR_W-1:0] target_reg_sel;
  logic                  target_valid, target_read;
  logic                  cmd_strobe, rd_strobe, wr_strobe;
  logic [SCD_DATA_W-1:0] rd_data = '0;
  logic [SCD_DATA_W-1:0] wr_data;
  int                    n_fail = 0;
  int                    total_checks = 0;
  int                    n_cmd = 0, n_rd = 0, n_wr = 0;

  always #2.5 sys_clk = ~sys_clk;

  scd_decoder i_scd_decoder (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .spi_sclk      (spi_sclk),
    .spi_cs_n      (spi_cs_n),
    .spi_din       (spi_din),
    .spi_dout      (spi_dout),
    .spi_dout_oe   (spi_dout_oe),
    .command_reg   (command_reg),
    .target_reg_sel(target_reg_sel),
    .target_valid  (target_valid),
    .target_read   (target_read),
    .cmd_strobe    (cmd_strobe),
    .rd_strobe     (rd_strobe),
    .rd_data       (rd_data),
    .wr_strobe     (wr_strobe),
    .wr_data       (wr_data)
  );

  scd_host_model i_scd_host_model (
    .spi_sclk   (spi_sclk),
    .spi_cs_n   (spi_cs_n),
    .spi_din    (spi_din),
    .spi_dout   (spi_dout),
    .spi_dout_oe(spi_dout_oe)
  );

  // distinct value per address so a wrong selection shows in the data
  function automatic logic [23:0] bank(input logic [5:0] a);
    return {a, ~a, a, ~a};
  endfunction

  function automatic int len_of(input logic [5:0] a);
    if (a == 6'h00) return 8;
    if (a == 6'h03 || a == 6'h04) return 24;
    if (a[5:2] == 4'hC || a[5:2] == 4'hE) return 24;
    if (a inside {6'h01, 6'h02, 6'h06, 6'h07}) return 16;
    if (a[5:2] inside {4'h4, 4'h8, 4'hA}) return 16;
    return 0;
  endfunction

  always @(negedge sys_clk) rd_data <= bank(target_reg_sel);

  // strobes are counted mid-cycle, away from the edge that launches them
  always @(negedge sys_clk) begin
    if (cmd_strobe === 1'b1) n_cmd++;
    if (rd_strobe === 1'b1) n_rd++;
    if (wr_strobe === 1'b1) n_wr++;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic t_reset;
    @(negedge sys_clk) rst_n <= 1'b0;
    repeat (12) @(negedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({16'h0, command_reg}, 24'h0, "command after reset");
    chk({18'h0, target_reg_sel}, 24'h0, "select after reset");
    chk({22'h0, target_valid, target_read}, 24'h0, "flags after reset");
  endtask

  task automatic one_access(input logic dir, input logic [5:0] a);
    int          l, c0, r0, w0;
    logic [23:0] got, exp, wd;
    l  = len_of(a);
    c0 = n_cmd;
    r0 = n_rd;
    w0 = n_wr;
    wd = 24'h9C36E5 ^ {a, a, a, a};
    exp = (dir ? bank(a) : wd) & ((24'h1 << l) - 24'h1);
    i_scd_host_model.xfer({1'b0, dir, a}, (l == 0) ? 8 : l, wd, got);
    repeat (20) @(negedge sys_clk);
    chk({16'h0, command_reg}, {16'h0, 1'b0, dir, a}, "command");
    chk({18'h0, target_reg_sel}, {18'h0, a}, "select");
    chk({23'h0, target_valid}, {23'h0, l != 0}, "valid");
    chk({23'h0, target_read}, {23'h0, dir}, "direction");
    chk(24'(n_cmd - c0), 24'h1, "command strobes");
    chk(24'(n_rd - r0), {23'h0, dir && l != 0}, "read strobes");
    chk(24'(n_wr - w0), {23'h0, !dir && l != 0}, "write strobes");
    if (l != 0 && dir) chk(got, exp, "read data");
    if (l != 0 && !dir) chk(wr_data, exp, "write data");
  endtask

  // every address code in both directions, unlisted ones included
  task automatic t_sweep;
    for (int d = 0; d < 2; d++) begin
      for (int a = 0; a < 64; a++) one_access(d[0], a[5:0]);
    end
  endtask

  // a byte with the top bit set starts nothing; the next byte is a command
  task automatic t_bad_start;
    int          c0, w0;
    logic [23:0] got, wd0;
    c0  = n_cmd;
    w0  = n_wr;
    wd0 = wr_data;
    i_scd_host_model.xfer(8'h81, 8, 24'h000020, got);
    repeat (20) @(negedge sys_clk);
    chk(24'(n_cmd - c0), 24'h1, "strobes after bad start");
    chk({16'h0, command_reg}, 24'h000020, "command after bad start");
    chk(24'(n_wr - w0), 24'h0, "write from cut frame");
    chk(wr_data, wd0, "data from cut frame");
  endtask

  initial begin
    #400000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    t_reset();
    t_sweep();
    t_bad_start();
    t_reset();
    close_out();
  end
endmodule  // test_serial_command_register_decoder
